/* File: hdl/ncs_pkg.sv */
// Shared constants, operation codes and state layout of the sequencer core.
package ncs_pkg;

  localparam int WC_WIDTH    = 6;
  localparam int BANK_WIDTH  = 4;
  localparam int NIB_WIDTH   = 4;
  localparam int STACK_DEPTH = 2;
  localparam int LINE_COUNT  = 10;
  localparam int PROG_WORDS  = 1024;
  localparam int PAGE_WORDS  = 64;
  localparam int CYCLE_CLKS  = 6;
  localparam int HIGH_LINE_BASE = 8;

  localparam logic [5:0] WC_RESET    = 6'h00;
  localparam logic [3:0] BANK_RESET  = 4'h0;
  localparam logic [3:0] NIB_RESET   = 4'h0;
  localparam logic [1:0] PP_RESET    = 2'h0;
  localparam logic       FLAG_RESET  = 1'b1;
  localparam logic [9:0] LINES_RESET = 10'h000;
  localparam logic [3:0] NO_LINE     = 4'hF;

  // Machine cycle phases, one clock each.
  typedef enum logic [5:0] {
    PH0 = 6'h01,
    PH1 = 6'h02,
    PH2 = 6'h04,
    PH3 = 6'h08,
    PH4 = 6'h10,
    PH5 = 6'h20
  } ncs_phase_t;

  // Decoded operations presented by the instruction decoder.
  typedef enum logic [3:0] {
    OP_NOP        = 4'h0,
    OP_LOAD_STAGE = 4'h1,
    OP_JUMP       = 4'h2,
    OP_CALL       = 4'h3,
    OP_RETURN     = 4'h4,
    OP_LOAD_A_IMM = 4'h5,
    OP_LOAD_A_MEM = 4'h6,
    OP_STORE_A    = 4'h7,
    OP_ADD_MEM    = 4'h8,
    OP_SUB_MEM    = 4'h9,
    OP_CMP_NE_IMM = 4'hA,
    OP_LOAD_WP    = 4'hB,
    OP_LOAD_PP    = 4'hC,
    OP_INC_WP     = 4'hD,
    OP_SET_LINE   = 4'hE,
    OP_CLR_LINE   = 4'hF
  } ncs_op_t;

  typedef struct packed {
    logic                   pinSync1;
    logic                   pinSync2;
    logic                   pinSync3;
    logic                   pinLow;
    ncs_phase_t             phase;
    logic [WC_WIDTH-1:0]    wordCounter;
    logic [BANK_WIDTH-1:0]  romBank;
    logic [BANK_WIDTH-1:0]  bankStaging;
    logic [STACK_DEPTH-1:0][WC_WIDTH+BANK_WIDTH-1:0] returnStack;
    logic [NIB_WIDTH-1:0]   acc;
    logic [NIB_WIDTH-1:0]   wordPointer;
    logic [1:0]             pagePointer;
    logic                   conditionFlag;
    logic [LINE_COUNT-1:0]  outputLines;
    logic                   ramWrEn;
    logic [NIB_WIDTH-1:0]   ramWrData;
    logic                   fetchStrobe;
  } ncs_state_t;

endpackage

/* File: hdl/ncs_nibble_core_sequencer.sv */
// Program sequencer, data pointers, accumulator and adder of a nibble core.
//
// Overview of operation
// [RULE1] Program space is 1024 bytes: 16 pages of 64 words.
// [RULE2] Program address is page register high, word counter low six bits.
// [RULE3] Page register holds 0..15 and changes only on page-changing ops.
// [RULE4] Staging latch is loaded by its op, copied to page on taken jump.
// [RULE5] Return restores caller page and word counter in one step.
// [RULE6] Word counter is six bits and advances once per fetch.
// [RULE7] Power-on clears word counter and page register.
// [RULE8] Return stack keeps two entries of word plus page.
// [RULE9] Data address is page pointer bit zero and four-bit word pointer.
// [RULE10] Page pointer bit one with word pointer 0/1 picks lines 8/9.
// [RULE11] Word pointer addresses data, selects lines and carrier mode.
// [RULE12] Accumulator is a four-bit operand and result register.
// [RULE13] Subtraction adds inverted accumulator plus one.
// [RULE14] Flag is set on carry out or on unequal comparison.
// [RULE15] One instruction completes every six-clock machine cycle.
// [RULE16] Jump is taken only with the flag at one.
// [RULE17] Low reset pin forces word zero of page zero.
// [RULE18] Word counter wraps from 63 to 0 inside the same page.
// [RULE19] Taken call pushes return address; third call drops the oldest.
`timescale 1ns/1ps
`default_nettype none

module ncs_nibble_core_sequencer (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        resetPinN,
  input  wire logic [3:0]  opCode,
  input  wire logic [5:0]  opOperand,
  input  wire logic [3:0]  memData,
  output logic      [9:0]  progAddr, // RULE1
  output logic             fetchStrobe,
  output logic      [4:0]  ramAddr,
  output logic             ramWrEn,
  output logic      [3:0]  ramWrData,
  output logic      [3:0]  accumulator,
  output logic      [3:0]  wordPointer,
  output logic             portBankSelectBit,
  output logic      [3:0]  carrierModeSel,
  output logic             conditionFlag,
  output logic      [9:0]  outputLines
);

  // ---------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------

  // Picks the output line addressed by the pointers, or none.
  function automatic logic [3:0] lineIndex(input logic       bankBit,
                                           input logic [3:0] wp);
    logic [3:0] idx;
    idx = ncs_pkg::NO_LINE;
    if (!bankBit && wp < 4'(ncs_pkg::HIGH_LINE_BASE))
      idx = wp;
    else if (bankBit && wp < 4'h2)
      idx = 4'(ncs_pkg::HIGH_LINE_BASE) + wp;
    return idx;
  endfunction

  // Four-bit add with carry in; bit four is the carry out.
  function automatic logic [4:0] nibbleAdd(input logic [3:0] a,
                                           input logic [3:0] b,
                                           input logic       cin);
    return {1'b0, a} + {1'b0, b} + {4'h0, cin};
  endfunction

  // ---------------------------------------------------------------------
  // State and next-state logic
  // ---------------------------------------------------------------------

  ncs_pkg::ncs_state_t st;
  ncs_pkg::ncs_state_t next_st;

  logic                  exec;
  ncs_pkg::ncs_op_t      op;
  logic [5:0]            wcPlus;
  logic [9:0]            returnAddr;
  logic [4:0]            aluSum;
  logic [3:0]            lineSel;

  assign op     = ncs_pkg::ncs_op_t'(opCode);
  assign exec   = (st.phase == ncs_pkg::PH5) && !st.pinLow; // RULE15
  assign wcPlus = st.wordCounter + 6'h01; // RULE18
  assign returnAddr = {st.romBank, wcPlus};
  assign lineSel    = lineIndex(st.pagePointer[1], st.wordPointer); // RULE10

  always_comb
  begin
    next_st = st; // RULE3
    aluSum  = 5'h00;
    // The first stage feeds only the second; the filtered level moves
    // once the second and third stages agree.
    next_st.pinSync1 = resetPinN;
    next_st.pinSync2 = st.pinSync1;
    next_st.pinSync3 = st.pinSync2;
    if (st.pinSync2 == st.pinSync3)
      next_st.pinLow = !st.pinSync3;
    next_st.ramWrEn     = 1'b0;
    next_st.fetchStrobe = (st.phase == ncs_pkg::PH5) && !st.pinLow;

    case (st.phase)
      ncs_pkg::PH0: next_st.phase = ncs_pkg::PH1;
      ncs_pkg::PH1: next_st.phase = ncs_pkg::PH2;
      ncs_pkg::PH2: next_st.phase = ncs_pkg::PH3;
      ncs_pkg::PH3: next_st.phase = ncs_pkg::PH4;
      ncs_pkg::PH4: next_st.phase = ncs_pkg::PH5;
      ncs_pkg::PH5: next_st.phase = ncs_pkg::PH0; // RULE15
      default:      next_st.phase = ncs_pkg::PH0;
    endcase

    if (exec)
    begin
      next_st.wordCounter   = wcPlus; // RULE6
      next_st.conditionFlag = 1'b1;
      case (op)
        ncs_pkg::OP_LOAD_STAGE:
          next_st.bankStaging = opOperand[3:0]; // RULE4
        ncs_pkg::OP_JUMP:
          if (st.conditionFlag) // RULE16
          begin
            next_st.wordCounter = opOperand;
            next_st.romBank     = st.bankStaging; // RULE4
          end
        ncs_pkg::OP_CALL:
          if (st.conditionFlag)
          begin
            // The oldest entry falls off the bottom on a third call.
            next_st.returnStack[1] = st.returnStack[0]; // RULE19
            next_st.returnStack[0] = returnAddr; // RULE8
            next_st.wordCounter    = opOperand;
            next_st.romBank        = st.bankStaging; // RULE4
          end
        ncs_pkg::OP_RETURN:
        begin
          next_st.romBank        = st.returnStack[0][9:6]; // RULE5
          next_st.wordCounter    = st.returnStack[0][5:0];
          next_st.returnStack[0] = st.returnStack[1];
        end
        ncs_pkg::OP_LOAD_A_IMM:
          next_st.acc = opOperand[3:0]; // RULE12
        ncs_pkg::OP_LOAD_A_MEM:
          next_st.acc = memData;
        ncs_pkg::OP_STORE_A:
        begin
          next_st.ramWrEn   = 1'b1; // RULE9
          next_st.ramWrData = st.acc;
        end
        ncs_pkg::OP_ADD_MEM:
        begin
          aluSum                = nibbleAdd(memData, st.acc, 1'b0);
          next_st.acc           = aluSum[3:0];
          next_st.conditionFlag = aluSum[4]; // RULE14
        end
        ncs_pkg::OP_SUB_MEM:
        begin
          aluSum                = nibbleAdd(memData, ~st.acc, 1'b1); // RULE13
          next_st.acc           = aluSum[3:0];
          next_st.conditionFlag = aluSum[4]; // RULE14
        end
        ncs_pkg::OP_CMP_NE_IMM:
          next_st.conditionFlag = (st.acc != opOperand[3:0]); // RULE14
        ncs_pkg::OP_LOAD_WP:
          next_st.wordPointer = opOperand[3:0]; // RULE11
        ncs_pkg::OP_LOAD_PP:
          next_st.pagePointer = opOperand[1:0];
        ncs_pkg::OP_INC_WP:
        begin
          aluSum                = nibbleAdd(st.wordPointer, 4'h0, 1'b1);
          next_st.wordPointer   = aluSum[3:0];
          next_st.conditionFlag = aluSum[4];
        end
        ncs_pkg::OP_SET_LINE:
          if (lineSel < 4'(ncs_pkg::LINE_COUNT))
            next_st.outputLines[lineSel] = 1'b1; // RULE11
        ncs_pkg::OP_CLR_LINE:
          if (lineSel < 4'(ncs_pkg::LINE_COUNT))
            next_st.outputLines[lineSel] = 1'b0;
        default: ;
      endcase
    end

    if (st.pinLow)
    begin
      next_st.wordCounter = ncs_pkg::WC_RESET; // RULE17
      next_st.romBank     = ncs_pkg::BANK_RESET;
      next_st.phase       = ncs_pkg::PH0;
      next_st.outputLines = ncs_pkg::LINES_RESET;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st <= '0;
      st.pinSync1      <= 1'b1;
      st.pinSync2      <= 1'b1;
      st.pinSync3      <= 1'b1;
      st.phase         <= ncs_pkg::PH0;
      st.wordCounter   <= ncs_pkg::WC_RESET; // RULE7
      st.romBank       <= ncs_pkg::BANK_RESET;
      st.bankStaging   <= ncs_pkg::BANK_RESET;
      st.acc           <= ncs_pkg::NIB_RESET;
      st.wordPointer   <= ncs_pkg::NIB_RESET;
      st.pagePointer   <= ncs_pkg::PP_RESET;
      st.conditionFlag <= ncs_pkg::FLAG_RESET;
      st.outputLines   <= ncs_pkg::LINES_RESET;
    end
    else
      st <= next_st;
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------

  assign progAddr          = {st.romBank, st.wordCounter}; // RULE2
  assign fetchStrobe       = st.fetchStrobe;
  assign ramAddr           = {st.pagePointer[0], st.wordPointer}; // RULE9
  assign ramWrEn           = st.ramWrEn;
  assign ramWrData         = st.ramWrData;
  assign accumulator       = st.acc;
  assign wordPointer       = st.wordPointer;
  assign portBankSelectBit = st.pagePointer[1];
  assign carrierModeSel    = st.wordPointer; // RULE11
  assign conditionFlag     = st.conditionFlag;
  assign outputLines       = st.outputLines;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_cycle_six_clocks: assert property ( // RULE15
    (st.phase == ncs_pkg::PH0 && !st.pinLow && !next_st.pinLow)
      |=> (st.phase != ncs_pkg::PH0) [*5] ##1 (st.phase == ncs_pkg::PH0)
      or ##[1:5] st.pinLow)
    else $error("machine cycle is not six clocks");

  a_wc_advance: assert property ( // RULE6
    (exec && op != ncs_pkg::OP_JUMP && op != ncs_pkg::OP_CALL
      && op != ncs_pkg::OP_RETURN && !next_st.pinLow)
      |=> st.wordCounter == 6'($past(st.wordCounter) + 6'h01)
          && st.romBank == $past(st.romBank))
    else $error("word counter did not advance within the page");

  a_jump_taken: assert property ( // RULE16
    (exec && op == ncs_pkg::OP_JUMP && st.conditionFlag && !next_st.pinLow)
      |=> st.wordCounter == $past(opOperand)
          && st.romBank == $past(st.bankStaging))
    else $error("taken jump did not load target and page");

  a_jump_skipped: assert property ( // RULE16
    (exec && op == ncs_pkg::OP_JUMP && !st.conditionFlag && !next_st.pinLow)
      |=> st.romBank == $past(st.romBank)
          && st.wordCounter == 6'($past(st.wordCounter) + 6'h01))
    else $error("jump taken with the flag clear");

  a_stage_no_page: assert property ( // RULE4
    (exec && op == ncs_pkg::OP_LOAD_STAGE && !next_st.pinLow)
      |=> st.bankStaging == $past(opOperand[3:0])
          && st.romBank == $past(st.romBank))
    else $error("staging load changed the page");

  a_call_push: assert property ( // RULE19
    (exec && op == ncs_pkg::OP_CALL && st.conditionFlag && !next_st.pinLow)
      |=> st.returnStack[0] == $past(returnAddr)
          && st.returnStack[1] == $past(st.returnStack[0]))
    else $error("call did not push the return address");

  a_return_pop: assert property ( // RULE5
    (exec && op == ncs_pkg::OP_RETURN && !next_st.pinLow)
      |=> {st.romBank, st.wordCounter} == $past(st.returnStack[0]))
    else $error("return did not restore page and word");

  a_sub_complement: assert property ( // RULE13
    (exec && op == ncs_pkg::OP_SUB_MEM && !next_st.pinLow)
      |=> st.acc == 4'($past(memData) - $past(st.acc)))
    else $error("subtraction result wrong");

  a_compare_flag: assert property ( // RULE14
    (exec && op == ncs_pkg::OP_CMP_NE_IMM && !next_st.pinLow)
      |=> st.conditionFlag == ($past(st.acc) != $past(opOperand[3:0])))
    else $error("compare flag wrong");

  a_pin_reset_addr: assert property ( // RULE17
    st.pinLow |=> progAddr == 10'h000 && outputLines == 10'h000)
    else $error("reset pin did not clear the address");

  a_pin_filter: assert property ( // RULE17
    !resetPinN [*3] |-> ##2 st.pinLow)
    else $error("reset pin level not taken after three stages");

endmodule

`default_nettype wire

/* File: sim/ncs_mem_model.sv */
// Data memory model that serves the sequencer's data pointer.
`timescale 1ns/1ps
`default_nettype none

module ncs_mem_model (
  input  wire logic       clk,
  input  wire logic [4:0] ramAddr,
  input  wire logic       ramWrEn,
  input  wire logic [3:0] ramWrData,
  output logic      [3:0] memData
);
  logic [3:0] mem [32] = '{default: 4'h0};

  assign memData = mem[ramAddr];

  always @(posedge clk)
  begin
    if (ramWrEn === 1'b1)
      mem[ramAddr] <= ramWrData;
  end
endmodule

`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench of the nibble core sequencer.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic       resetPinN = 1'b1;
  logic [3:0] opCode = 4'h0;
  logic [5:0] opOperand = 6'h00;
  logic [3:0] memData, ramWrData, accumulator, wordPointer, carrierModeSel;
  logic [9:0] progAddr, outputLines, pa, lines;
  logic [4:0] ramAddr, r;
  logic       fetchStrobe, ramWrEn, portBankSelectBit, conditionFlag;
  logic [9:0] stk [$];
  logic [3:0] stg [3] = '{4'h2, 4'h7, 4'h3};
  logic [5:0] tgt [3] = '{6'h10, 6'h20, 6'h30};
  logic [3:0] av [4] = '{4'h8, 4'h1, 4'hA, 4'h2};
  int         error_cnt = 0;
  int         checked = 0;
  int         cyc;

  always #10 clk = ~clk;

  ncs_nibble_core_sequencer ncs_nibble_core_sequencer_i (
    .clk, .reset, .resetPinN, .opCode, .opOperand, .memData, .progAddr,
    .fetchStrobe, .ramAddr, .ramWrEn, .ramWrData, .accumulator,
    .wordPointer, .portBankSelectBit, .carrierModeSel, .conditionFlag,
    .outputLines
  );

  ncs_mem_model ncs_mem_model_i (
    .clk, .ramAddr, .ramWrEn, .ramWrData, .memData
  );

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [9:0] seen,
                     input logic [9:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Waits at falling edges for the next machine cycle to start.
  task automatic sync();
    cyc = 0;
    do
    begin
      @(negedge clk);
      cyc++;
    end while (fetchStrobe !== 1'b1 && cyc < 40);
    chk("fetch wait", 10'(cyc < 40), 10'h001);
  endtask

  task automatic exec(input ncs_pkg::ncs_op_t op, input logic [5:0] arg);
    opCode = op;
    opOperand = arg;
    sync();
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #100000;
    error_cnt++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(negedge clk);
    chk("reset addr", progAddr, 10'h000);
    chk("reset flag", 10'(conditionFlag), 10'h001);
    reset = 1'b0;
    for (int i = 1; i <= 3; i++)
    begin
      exec(ncs_pkg::OP_NOP, 6'h00);
      chk("seq addr", progAddr, 10'(i));
    end
    chk("cycle len", 10'(cyc), 10'h006);
    $display("test fetch done");
    exec(ncs_pkg::OP_LOAD_STAGE, 6'h05);
    chk("stage only", progAddr, 10'h004);
    exec(ncs_pkg::OP_CMP_NE_IMM, 6'h00);
    chk("equal flag", 10'(conditionFlag), 10'h000);
    exec(ncs_pkg::OP_JUMP, 6'h3F);
    chk("untaken", progAddr, 10'h006);
    exec(ncs_pkg::OP_NOP, 6'h00);
    exec(ncs_pkg::OP_JUMP, 6'h3F);
    chk("taken", progAddr, 10'h17F);
    exec(ncs_pkg::OP_NOP, 6'h00);
    chk("wrap", progAddr, 10'h140);
    $display("test jump done");
    pa = 10'h140;
    for (int i = 0; i < 3; i++)
    begin
      exec(ncs_pkg::OP_LOAD_STAGE, {2'h0, stg[i]});
      exec(ncs_pkg::OP_CALL, tgt[i]);
      stk.push_front(pa + 10'h002);
      pa = {stg[i], tgt[i]};
      chk("call", progAddr, pa);
    end
    for (int j = 0; j < 3; j++)
    begin
      exec(ncs_pkg::OP_RETURN, 6'h00);
      chk("return", progAddr, stk[(j < 2) ? j : 1]);
    end
    $display("test stack done");
    exec(ncs_pkg::OP_LOAD_A_IMM, 6'h09);
    chk("acc", 10'(accumulator), 10'h009);
    exec(ncs_pkg::OP_LOAD_WP, 6'h03);
    exec(ncs_pkg::OP_LOAD_PP, 6'h01);
    chk("ram addr", 10'(ramAddr), 10'h013);
    chk("carrier sel", 10'(carrierModeSel), 10'h003);
    exec(ncs_pkg::OP_STORE_A, 6'h00);
    chk("write", {ramWrEn, 5'h00, ramWrData}, 10'h209);
    exec(ncs_pkg::OP_LOAD_PP, 6'h00);
    exec(ncs_pkg::OP_LOAD_A_MEM, 6'h00);
    chk("other page", 10'(accumulator), 10'h000);
    for (int k = 0; k < 4; k++)
    begin
      exec(ncs_pkg::OP_LOAD_PP, 6'h01);
      exec(ncs_pkg::OP_LOAD_A_IMM, {2'h0, av[k]});
      exec((k % 3 == 0) ? ncs_pkg::OP_ADD_MEM : ncs_pkg::OP_SUB_MEM, 6'h00);
      r = (k % 3 == 0) ? 5'h09 + {1'b0, av[k]}
                       : 5'h09 + {1'b0, ~av[k]} + 5'h01;
      chk("alu", {5'h00, conditionFlag, accumulator}, 10'(r));
    end
    exec(ncs_pkg::OP_CMP_NE_IMM, 6'h03);
    chk("cmp", {5'h00, conditionFlag, accumulator}, 10'h01B);
    $display("test alu done");
    lines = 10'h000;
    for (int x = 0; x < 2; x++)
    begin
      for (int y = 0; y < 2; y++)
      begin
        exec(ncs_pkg::OP_LOAD_PP, 6'(x * 2));
        exec(ncs_pkg::OP_LOAD_WP, 6'(y));
        exec(ncs_pkg::OP_SET_LINE, 6'h00);
        lines[x * 8 + y] = 1'b1;
        chk("bank bit", 10'(portBankSelectBit), 10'(x));
        chk("lines", outputLines, lines);
      end
    end
    exec(ncs_pkg::OP_LOAD_WP, 6'h02);
    exec(ncs_pkg::OP_SET_LINE, 6'h00);
    chk("no line", outputLines, lines);
    exec(ncs_pkg::OP_LOAD_WP, 6'h0F);
    exec(ncs_pkg::OP_INC_WP, 6'h00);
    chk("wp wrap", {5'h00, conditionFlag, wordPointer}, 10'h010);
    exec(ncs_pkg::OP_CLR_LINE, 6'h00);
    lines[8] = 1'b0;
    chk("clr line", outputLines, lines);
    $display("test lines done");
    resetPinN = 1'b0;
    repeat (12) @(negedge clk);
    chk("pin addr", progAddr, 10'h000);
    chk("pin lines", outputLines, 10'h000);
    chk("pin fetch", 10'(fetchStrobe), 10'h000);
    resetPinN = 1'b1;
    exec(ncs_pkg::OP_NOP, 6'h00);
    chk("resume", progAddr, 10'h001);
    exec(ncs_pkg::OP_NOP, 6'h00);
    chk("resume next", progAddr, 10'h002);
    $display("test pin reset done");
    end_sim();
  end
endmodule

`default_nettype wire
